// File: rtl/stage_sequencer.sv
// start/stop and back-end fault restart sequencer of the pwm power stage
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
module stage_sequencer #(
    parameter int unsigned TICK_DIV = seq_pkg::TICK_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    input  wire seq_pkg::reg_req_t  req,
    output logic [7:0]              rdata,
    input  wire logic               shutdown_cmd,
    input  wire logic               power_down_pin_b,
    input  wire logic               backend_err,
    output seq_pkg::stage_ctl_t     stage_ctl,
    output logic                    trim_apply,
    output logic                    trim_done
);
    import seq_pkg::*;

    if (TICK_DIV < 2) begin : g_bad_div
        $error("stage_sequencer: TICK_DIV must be at least 2");
    end

    // ------------------------------------------------------------
    // interval lookup
    // ------------------------------------------------------------
    function automatic logic [17:0] ss_ticks(input logic [4:0] code);
        logic [17:0] t;
        t = 18'h0;
        if (code[4:3] != 2'b00) begin
            t = 18'(SS_TENTHS[code - 5'd8]);
        end
        return t;
    endfunction

    function automatic logic [17:0] bk_ticks(input logic [3:0] code);
        logic [3:0] idx;
        idx = (code >= 4'ha) ? 4'd8 : code - 4'd2;
        return 18'(BK_MS[idx] * 10);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [4:0]  ss_code_ff;
    logic [4:0]  nxt_ss_code;
    logic        trim_sel_ff;
    logic        nxt_trim_sel;
    logic        rsv7_ff;
    logic        nxt_rsv7;
    logic [3:0]  bk_code_ff;
    logic [3:0]  nxt_bk_code;
    logic        bk_locked_ff;
    logic        nxt_bk_locked;
    logic        trim_busy_ff;
    logic        nxt_trim_busy;
    logic [6:0]  trim_cnt_ff;
    logic [6:0]  nxt_trim_cnt;
    logic        trim_done_ff;
    logic        nxt_trim_done;
    logic        trim_apply_ff;
    logic        nxt_trim_apply;
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;

    seq_state_t  st_ff;
    seq_state_t  nxt_st;
    logic        prev_sd_ff;
    logic        prev_pd_ff;
    stage_ctl_t  ctl_ff;
    stage_ctl_t  nxt_ctl;
    logic        tmr_load;
    logic [17:0] tmr_val;
    logic        tmr_exp;

    logic        wr_ss;
    logic        wr_trim;
    logic        wr_bk;
    logic        want_off;

    assign wr_ss   = req.wr && (req.addr == ADDR_START_STOP);
    assign wr_trim = req.wr && (req.addr == ADDR_OSC_TRIM);
    assign wr_bk   = req.wr && (req.addr == ADDR_BKND);
    assign want_off = shutdown_cmd || !power_down_pin_b;

    always_comb begin
        nxt_ss_code    = ss_code_ff;
        nxt_trim_sel   = trim_sel_ff;
        nxt_rsv7       = rsv7_ff;
        nxt_bk_code    = bk_code_ff;
        nxt_bk_locked  = bk_locked_ff;
        nxt_trim_busy  = trim_busy_ff;
        nxt_trim_cnt   = trim_cnt_ff;
        nxt_trim_done  = trim_done_ff;
        nxt_trim_apply = 1'b0;
        nxt_rdata      = 8'h00;
        if (wr_ss) begin
            nxt_ss_code = req.wdata[4:0];
        end
        if (wr_trim) begin
            nxt_trim_sel = req.wdata[TRIM_SEL_BIT];
            nxt_rsv7     = req.wdata[TRIM_RSV7_BIT];
            if (req.wdata == 8'h00) begin
                nxt_trim_busy  = 1'b1;
                nxt_trim_apply = 1'b1;
                nxt_trim_cnt   = 7'(TRIM_CYCLES);
                nxt_trim_done  = 1'b0;
            end
        end
        if (trim_busy_ff && !(wr_trim && req.wdata == 8'h00)) begin
            if (trim_cnt_ff == 7'h1) begin
                nxt_trim_busy = 1'b0;
                nxt_trim_done = 1'b1;
            end
            nxt_trim_cnt = trim_cnt_ff - 7'h1;
        end
        if (wr_bk && !bk_locked_ff && req.wdata[7:4] == 4'h0
            && req.wdata[3:1] != 3'b000) begin
            nxt_bk_code   = req.wdata[3:0];
            nxt_bk_locked = 1'b1;
        end
        if (req.rd) begin
            case (req.addr)
                ADDR_START_STOP: nxt_rdata = {3'h0, ss_code_ff};
                ADDR_OSC_TRIM:   nxt_rdata = {rsv7_ff, trim_done_ff, 4'h0,
                                              trim_sel_ff, 1'b0};
                ADDR_BKND:       nxt_rdata = {4'h0, bk_code_ff};
                ADDR_STATUS:     nxt_rdata = {4'h0, bk_locked_ff, ctl_ff};
                default:         nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ss_code_ff    <= RST_START_STOP;
            trim_sel_ff   <= 1'b1;
            rsv7_ff       <= 1'b1;
            bk_code_ff    <= RST_BKND;
            bk_locked_ff  <= 1'b0;
            trim_busy_ff  <= 1'b0;
            trim_cnt_ff   <= 7'h0;
            trim_done_ff  <= 1'b0;
            trim_apply_ff <= 1'b0;
            rdata_ff      <= 8'h00;
        end else if (ce) begin
            ss_code_ff    <= nxt_ss_code;
            trim_sel_ff   <= nxt_trim_sel;
            rsv7_ff       <= nxt_rsv7;
            bk_code_ff    <= nxt_bk_code;
            bk_locked_ff  <= nxt_bk_locked;
            trim_busy_ff  <= nxt_trim_busy;
            trim_cnt_ff   <= nxt_trim_cnt;
            trim_done_ff  <= nxt_trim_done;
            trim_apply_ff <= nxt_trim_apply;
            rdata_ff      <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // stage state machine
    // ------------------------------------------------------------
    tick_timer #(
        .TICK_DIV (TICK_DIV)
    ) u_timer (
        .clk      (clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .load     (tmr_load),
        .load_val (tmr_val),
        .expired  (tmr_exp)
    );

    always_comb begin
        nxt_st   = st_ff;
        nxt_ctl  = ctl_ff;
        tmr_load = 1'b0;
        tmr_val  = 18'h0;
        case (st_ff)
            ST_RUN, ST_HALTED: begin
                if (want_off != (prev_sd_ff || !prev_pd_ff)) begin
                    if (ss_ticks(ss_code_ff) == 18'h0) begin
                        nxt_st  = want_off ? ST_HALTED : ST_RUN;
                        nxt_ctl = '{pwm_half_duty: 1'b0, stage_reset: 1'b0,
                                    stage_run: !want_off};
                    end else begin
                        tmr_load = 1'b1;
                        tmr_val  = ss_ticks(ss_code_ff);
                        nxt_st   = ST_SOFT;
                        nxt_ctl  = '{pwm_half_duty: 1'b1, stage_reset: 1'b0,
                                     stage_run: 1'b1};
                    end
                end
            end
            ST_SOFT: begin
                if (tmr_exp) begin
                    nxt_st  = want_off ? ST_HALTED : ST_RUN;
                    nxt_ctl = '{pwm_half_duty: 1'b0, stage_reset: 1'b0,
                                stage_run: !want_off};
                end
            end
            ST_FAULT_WAIT: begin
                if (tmr_exp) begin
                    nxt_st  = ST_RUN;
                    nxt_ctl = '{pwm_half_duty: 1'b0, stage_reset: 1'b0,
                                stage_run: 1'b1};
                end
            end
            default: begin
                nxt_st = ST_HALTED;
            end
        endcase
        if (backend_err) begin
            tmr_load = 1'b1;
            tmr_val  = bk_ticks(bk_code_ff);
            nxt_st   = ST_FAULT_WAIT;
            nxt_ctl  = '{pwm_half_duty: 1'b0, stage_reset: 1'b1, stage_run: 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_ff      <= ST_HALTED;
            ctl_ff     <= '0;
            prev_sd_ff <= 1'b1;
            prev_pd_ff <= 1'b0;
        end else if (ce) begin
            st_ff      <= nxt_st;
            ctl_ff     <= nxt_ctl;
            prev_sd_ff <= shutdown_cmd;
            prev_pd_ff <= power_down_pin_b;
        end
    end

    assign rdata      = rdata_ff;
    assign stage_ctl  = ctl_ff;
    assign trim_apply = trim_apply_ff;
    assign trim_done  = trim_done_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_fault;
        ce && backend_err;
    endsequence

    property p_fault_halt;
        @(posedge clk) disable iff (!rst_b)
        s_fault |=> (ctl_ff.stage_reset && !ctl_ff.stage_run && !ctl_ff.pwm_half_duty);
    endproperty
    a_fault_halt: assert property (p_fault_halt) else $error("fault did not halt stage");

    property p_soft_half;
        @(posedge clk) disable iff (!rst_b)
        (st_ff == ST_SOFT) |-> ctl_ff.pwm_half_duty;
    endproperty
    a_soft_half: assert property (p_soft_half) else $error("soft interval not at half duty");

    property p_no_interval;
        @(posedge clk) disable iff (!rst_b)
        (ce && st_ff == ST_RUN && ss_code_ff[4:3] == 2'b00 && !backend_err)
        |=> (st_ff != ST_SOFT);
    endproperty
    a_no_interval: assert property (p_no_interval) else $error("interval with code 00xxx");

    property p_trim_start;
        @(posedge clk) disable iff (!rst_b)
        (ce && wr_trim && req.wdata == 8'h00) |=> (trim_apply_ff && !trim_done_ff);
    endproperty
    a_trim_start: assert property (p_trim_start) else $error("trim request not taken");

    property p_trim_done_stable;
        @(posedge clk) disable iff (!rst_b)
        (trim_done_ff && !(wr_trim && req.wdata == 8'h00)) |=> trim_done_ff;
    endproperty
    a_trim_done_stable: assert property (p_trim_done_stable) else $error("trim done dropped");

    property p_bk_lock;
        @(posedge clk) disable iff (!rst_b)
        bk_locked_ff |=> $stable(bk_code_ff);
    endproperty
    a_bk_lock: assert property (p_bk_lock) else $error("back-end written twice");

    property p_bk_rsv;
        @(posedge clk) disable iff (!rst_b)
        (wr_bk && req.wdata[3:1] == 3'b000) |=> $stable(bk_code_ff);
    endproperty
    a_bk_rsv: assert property (p_bk_rsv) else $error("reserved back-end value taken");

    property p_restart;
        @(posedge clk) disable iff (!rst_b)
        (st_ff == ST_FAULT_WAIT && tmr_exp && ce && !backend_err) |=> ctl_ff.stage_run;
    endproperty
    a_restart: assert property (p_restart) else $error("stage not restarted");

    property p_ss_rd;
        @(posedge clk) disable iff (!rst_b)
        (ce && req.rd && req.addr == ADDR_START_STOP) |=> (rdata_ff[7:5] == 3'h0);
    endproperty
    a_ss_rd: assert property (p_ss_rd) else $error("reserved start/stop bits nonzero");

endmodule

// File: rtl/seq_pkg.sv
// package: register map, field layout, reset values and timing for the start/stop sequencer
package seq_pkg;

    localparam int unsigned CLK_HZ = 250_000_000;

    // register offsets
    localparam logic [7:0] ADDR_START_STOP = 8'h1a;
    localparam logic [7:0] ADDR_OSC_TRIM   = 8'h1b;
    localparam logic [7:0] ADDR_BKND       = 8'h1c;
    localparam logic [7:0] ADDR_STATUS     = 8'h1d;

    // reset values
    localparam logic [4:0] RST_START_STOP  = 5'h0f;
    localparam logic [3:0] RST_BKND        = 4'h2;

    // field positions
    localparam int unsigned TRIM_DONE_BIT  = 6;
    localparam int unsigned TRIM_SEL_BIT   = 1;
    localparam int unsigned TRIM_RSV7_BIT  = 7;

    // trim engine takes this many cycles after the request
    localparam int unsigned TRIM_CYCLES    = 64;

    // one tick per 0.1 ms of interval
    localparam int unsigned TICK_US_X10    = 1000;
    localparam int unsigned TICK_CYCLES    = CLK_HZ / 10_000;

    // start/stop periods in tenths of a ms, codes 01000..11111
    localparam int unsigned SS_TENTHS [24] = '{
        165, 239, 314, 404, 539, 703, 942, 1257,
        1646, 2394, 3142, 4039, 5386, 7031, 9425, 12566,
        17281, 25136, 32991, 42417, 56556, 73837, 98973, 131964};

    // back-end periods in ms, codes 0010..1010+
    localparam int unsigned BK_MS [9] = '{
        299, 449, 598, 748, 898, 1047, 1197, 1346, 1496};

    typedef enum {
        ST_RUN,
        ST_SOFT,
        ST_HALTED,
        ST_FAULT_WAIT
    } seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef struct packed {
        logic pwm_half_duty;
        logic stage_reset;
        logic stage_run;
    } stage_ctl_t;

endpackage

// File: rtl/tick_timer.sv
// down counter of 0.1 ms ticks used for all sequencer intervals
`timescale 1ns/1ns
module tick_timer #(
    parameter int unsigned TICK_DIV = 25_000
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        load,
    input  wire logic [17:0] load_val,
    output logic             expired
);
    import seq_pkg::*;

    if (TICK_DIV < 2) begin : g_bad_div
        $error("tick_timer: TICK_DIV must be at least 2");
    end

    logic [17:0] cnt_ff;
    logic [17:0] nxt_cnt;
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic        exp_ff;
    logic        nxt_exp;

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_div = div_ff;
        nxt_exp = 1'b0;
        if (load) begin
            nxt_cnt = load_val;
            nxt_div = 32'(TICK_DIV - 1);
        end else if (cnt_ff != 18'h0) begin
            if (div_ff == 32'h0) begin
                nxt_div = 32'(TICK_DIV - 1);
                nxt_cnt = cnt_ff - 18'h1;
                nxt_exp = (cnt_ff == 18'h1);
            end else begin
                nxt_div = div_ff - 32'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_ff <= 18'h0;
            div_ff <= 32'h0;
            exp_ff <= 1'b0;
        end else if (ce) begin
            cnt_ff <= nxt_cnt;
            div_ff <= nxt_div;
            exp_ff <= nxt_exp;
        end
    end

    assign expired = exp_ff;

endmodule

// File: dv/power_stage_model.sv
// behavioural power stage that reports back-end errors on command
`timescale 1ns/1ns
module power_stage_model
    import seq_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire seq_pkg::stage_ctl_t stage_ctl,
    input  wire logic                fault_cmd,
    output logic                     backend_err
);
    // ---------------------------------------------------------------
    // fault reporting
    // ---------------------------------------------------------------
    // a stage that is not running cannot trip, so errors need run high
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            backend_err <= 1'b0;
        end else begin
            backend_err <= fault_cmd & stage_ctl.stage_run;
        end
    end
endmodule

// File: dv/test_pwm_stage_start_stop_sequencer.sv
// self-checking bench of the start/stop and fault restart sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR at %0t: got %h expected %h", $time, (g), (e)); end end
module test_pwm_stage_start_stop_sequencer;
    import seq_pkg::*;
    localparam int TD = 2;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       ce = 1'b1;
    reg_req_t   req = '0;
    logic [7:0] rdata;
    logic       shutdown_cmd = 1'b1;
    logic       power_down_pin_b = 1'b0;
    logic       backend_err;
    stage_ctl_t stage_ctl;
    logic       trim_apply;
    logic       trim_done;
    logic       fault_cmd = 1'b0;
    int         bad_count = 0;
    int         total_checks = 0;

    always #2 clk = ~clk;

    stage_sequencer #(.TICK_DIV(TD)) u_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .req(req),
        .rdata(rdata), .shutdown_cmd(shutdown_cmd), .power_down_pin_b(power_down_pin_b),
        .backend_err(backend_err), .stage_ctl(stage_ctl), .trim_apply(trim_apply),
        .trim_done(trim_done));
    power_stage_model u_stage (.clk(clk), .rst_b(rst_b), .stage_ctl(stage_ctl),
        .fault_cmd(fault_cmd), .backend_err(backend_err));

    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        `CHK(rdata, exp)
    endtask

    // half duty must appear, last the interval, then settle to exp_run
    task automatic soft_check(input int ticks, input logic exp_run);
        int n;
        n = 0;
        while (stage_ctl.pwm_half_duty !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(stage_ctl.pwm_half_duty, 1'b1)
        `CHK(stage_ctl.stage_run, 1'b1)
        n = 0;
        while (stage_ctl.pwm_half_duty === 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK((n >= ticks * TD - 2) && (n <= ticks * TD + 4), 1'b1)
        `CHK(stage_ctl.stage_run, exp_run)
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        `CHK(stage_ctl, 3'b000)
        `CHK(trim_done, 1'b0)
        rd_chk(ADDR_START_STOP, 8'h0f);
        rd_chk(ADDR_OSC_TRIM, 8'h82);
        rd_chk(ADDR_BKND, 8'h02);
        rd_chk(8'h30, 8'h00);
    endtask

    task automatic t_trim();
        int pulses;
        int first;
        pulses = 0;
        first = -1;
        wr_reg(ADDR_OSC_TRIM, 8'h00);
        // sample first: the apply pulse stands in the cycle right after the write
        for (int i = 0; i < 100; i++) begin
            #1;
            if (trim_apply === 1'b1) pulses++;
            if (trim_done === 1'b1 && first < 0) first = i;
            @(posedge clk);
        end
        #1;
        `CHK(pulses, 1)
        `CHK((first >= TRIM_CYCLES - 4) && (first <= TRIM_CYCLES + 4), 1'b1)
        `CHK(rdata, 8'h00)
        rd_chk(ADDR_OSC_TRIM, 8'h40);
        wr_reg(ADDR_OSC_TRIM, 8'h3d);
        rd_chk(ADDR_OSC_TRIM, 8'h40);
    endtask

    task automatic t_bknd_writes();
        wr_reg(ADDR_BKND, 8'h13);
        rd_chk(ADDR_BKND, 8'h02);
        wr_reg(ADDR_BKND, 8'h01);
        rd_chk(ADDR_BKND, 8'h02);
        wr_reg(ADDR_BKND, 8'h03);
        rd_chk(ADDR_BKND, 8'h03);
        wr_reg(ADDR_BKND, 8'h05);
        rd_chk(ADDR_BKND, 8'h03);
        rd_chk(ADDR_STATUS, 8'h08);
    endtask

    task automatic t_soft_start();
        wr_reg(ADDR_START_STOP, 8'he8);
        rd_chk(ADDR_START_STOP, 8'h08);
        @(posedge clk);
        shutdown_cmd <= 1'b0;
        power_down_pin_b <= 1'b1;
        soft_check(165, 1'b1);
    endtask

    // 449 ms restart wait is 4490 ticks
    task automatic t_backend_fault();
        int n;
        n = 0;
        @(posedge clk);
        fault_cmd <= 1'b1;
        @(posedge clk);
        fault_cmd <= 1'b0;
        while (stage_ctl.stage_reset !== 1'b1 && n < 6) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(stage_ctl.stage_reset, 1'b1)
        `CHK(stage_ctl.stage_run, 1'b0)
        `CHK(stage_ctl.pwm_half_duty, 1'b0)
        n = 0;
        while (stage_ctl.stage_run !== 1'b1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK((n >= 4490 * TD - 2) && (n <= 4490 * TD + 4), 1'b1)
    endtask

    task automatic t_soft_stop_and_direct();
        @(posedge clk);
        power_down_pin_b <= 1'b0;
        soft_check(165, 1'b0);
        wr_reg(ADDR_START_STOP, 8'h07);
        @(posedge clk);
        power_down_pin_b <= 1'b1;
        repeat (4) begin
            @(posedge clk);
            #1;
            `CHK(stage_ctl.pwm_half_duty, 1'b0)
        end
        `CHK(stage_ctl.stage_run, 1'b1)
        // shutdown command alone, still with no interval
        @(posedge clk);
        shutdown_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(stage_ctl, 3'b000)
        // a write while the clock enable is low must be lost
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(ADDR_START_STOP, 8'h10);
        ce <= 1'b1;
        rd_chk(ADDR_START_STOP, 8'h07);
    endtask

    // ---------------------------------------------------------------
    // verdict and run control
    // ---------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        t_reset_values();
        t_trim();
        t_bknd_writes();
        t_soft_start();
        t_backend_fault();
        t_soft_stop_and_direct();
        close_out();
    end
endmodule
